// >>> verilog/crf_top.sv
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Two banks of eight: four data, two address, static and frame base.
// - Data registers are 16 bits; first two also split into byte halves.
// - Data 0 with 2, and 1 with 3, join as 32 bits; higher upper.
// - Both address registers are 24 bits wide.
// - Static base and frame base are 24 bits, added to offsets.
// - Instruction pointer is 24 bits, next instruction address.
// - Vector table base is 24 bits, start of relocatable vectors.
// - Two 24-bit stack pointers; select bit 0 interrupt, 1 user.
// - Stack select cleared on hardware interrupt or trap number 0 to 31.
// - Status word is a 16-bit register of processor state.
// - Carry records carry out or borrow of affecting instructions.
// - Zero bit is 1 when result is zero, else 0.
// - Sign bit is 1 when result is negative, else 0.
// - Bank select 0 picks bank 0, 1 picks bank 1.
// - Overflow bit is 1 when result overflows, else 0.
// - Interrupt enable 0 blocks, 1 permits; cleared on any acknowledge.
// - Three-bit priority level; request accepted only when strictly higher.
// - Reserved status bits written 0; reads may return anything.
// - 16-Mbyte space decoded; peripheral area up to 0x0003ff.
// - Fixed vectors from 0xffffdc up; RAM starts at 0x000400.
module crf_top
	import crf_pkg::*;
(
	input wire logic mclk, // Core clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic ce, // Clock enable, freezes all state
	input wire logic gp_wr_en, // General register write strobe
	input wire logic [2:0] gp_wr_sel, // Register index in active bank
	input wire logic [1:0] gp_wr_mode, // Word, low, high or pair
	input wire logic [31:0] gp_wr_data, // Write data
	input wire logic [2:0] gp_rd_sel, // Read index in active bank
	input wire logic [1:0] gp_rd_mode, // Word, low, high or pair
	output logic [31:0] gp_rd_data, // Registered read data
	input wire logic ip_load, // Load instruction pointer
	input wire logic [23:0] ip_next, // Next instruction address
	output logic [23:0] ip_out, // Instruction pointer
	input wire logic vtb_load, // Load vector table base
	input wire logic [23:0] vtb_data, // New vector table base
	output logic [23:0] vtb_out, // Vector table base
	input wire logic sp_load, // Load active stack pointer
	input wire logic [23:0] sp_data, // New stack pointer
	output logic [23:0] sp_out, // Active stack pointer
	input wire logic psw_load, // Load whole status word
	input wire logic [15:0] psw_data, // New status word
	input wire logic alu_upd, // Arithmetic result valid
	input wire logic [3:0] alu_upd_mask, // Update O,S,Z,C (bit 3..0)
	input wire logic [1:0] alu_width, // Result width
	input wire logic [31:0] alu_result, // Arithmetic result
	input wire logic alu_carry, // Carry out or borrow
	input wire logic alu_ovf, // Signed overflow
	input wire logic int_req, // Maskable interrupt request
	input wire logic [2:0] int_req_lvl, // Its priority
	output logic int_take, // Request may be accepted
	input wire logic int_ack, // Hardware interrupt acknowledged
	input wire logic [2:0] int_new_lvl, // Level set on acknowledge
	input wire logic trap_exec, // Software trap executed
	input wire logic [5:0] trap_num, // Trap number
	output logic [15:0] psw_out, // Status word
	input wire logic [23:0] mem_addr, // Address to decode
	output logic [5:0] mem_region, // Ram,rom,spvec,fixvec,none,sfr
	input wire logic [7:0] s_axi_awaddr, // AXI4-Lite write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte enables
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready // Read data ready
);
	logic [23:0] gp_r [BANKS][BANK_REGS];
	logic [23:0] ip_r, vtb_r, usp_r, isp_r;
	logic [15:0] psw_r;
	logic [31:0] gp_rd_data_r;
	logic [5:0] region_r;
	logic bank;
	logic usel;
	logic [2:0] cpu_priority_level;
	logic sw_we;
	logic [7:0] sw_addr_r;
	logic [31:0] sw_data_r;
	logic [3:0] sw_strb_r;
	logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [31:0] sw_rd;
	logic sw_rd_hit, sw_wr_hit;
	logic z_nxt, s_nxt;
	logic [3:0] sw_gp_idx;
	logic [23:0] wr_mask;
	logic region_r_sfr, region_r_ram, region_r_rom, region_r_spv, region_r_fxv, region_r_none;

	assign bank = psw_r[PSW_B];
	assign usel = psw_r[PSW_U];
	assign cpu_priority_level = psw_r[PSW_IPL_HI:PSW_IPL_LO];
	assign sp_out = usel ? usp_r : isp_r;
	assign ip_out = ip_r;
	assign vtb_out = vtb_r;
	assign psw_out = psw_r;
	assign gp_rd_data = gp_rd_data_r;
	assign mem_region = region_r;

	assign int_take = int_req && psw_r[PSW_I] && (int_req_lvl > cpu_priority_level);

	// Software write lands when address and data are both held
	assign sw_we = aw_got_r && w_got_r && !bvalid_r;
	assign sw_gp_idx = sw_addr_r[5:2];
	// Byte enables expanded to the 24 stored bits
	assign wr_mask = {{8{sw_strb_r[2]}}, {8{sw_strb_r[1]}}, {8{sw_strb_r[0]}}};

	always_comb begin
		z_nxt = 1'b0;
		s_nxt = 1'b0;
		case (crf_width_t'(alu_width))
			crf_w8: begin
				z_nxt = (alu_result[BYTE_W-1:0] == 8'h00);
				s_nxt = alu_result[BYTE_W-1];
			end
			crf_w16: begin
				z_nxt = (alu_result[DATA_W-1:0] == 16'h0000);
				s_nxt = alu_result[DATA_W-1];
			end
			default: begin
				z_nxt = (alu_result == 32'h00000000);
				s_nxt = alu_result[31];
			end
		endcase
	end

	// banked registers, core port wins over software
	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int b = 0; b < BANKS; b++) begin
				for (int i = 0; i < BANK_REGS; i++) begin
					gp_r[b][i] <= REG_RST;
				end
			end
		end else if (ce) begin
			// Unaligned offsets are refused and must not land in a register
			if (sw_we && sw_wr_hit && (sw_addr_r < OFS_IP)) begin
				if (sw_gp_idx[2:0] < IX_A0) begin
					gp_r[sw_gp_idx[3]][sw_gp_idx[2:0]] <= (gp_r[sw_gp_idx[3]][sw_gp_idx[2:0]]
						& ~wr_mask & 24'h00ffff) | (sw_data_r[23:0] & wr_mask & 24'h00ffff);
				end else begin
					gp_r[sw_gp_idx[3]][sw_gp_idx[2:0]] <=
						(gp_r[sw_gp_idx[3]][sw_gp_idx[2:0]] & ~wr_mask)
						| (sw_data_r[23:0] & wr_mask);
				end
			end
			if (gp_wr_en) begin
				if (gp_wr_sel >= IX_A0) begin
					// address, static and frame base registers, 24 bits
					gp_r[bank][gp_wr_sel] <= gp_wr_data[23:0];
				end else begin
					case (crf_mode_t'(gp_wr_mode))
						crf_mode_low: begin
							if (gp_wr_sel <= IX_D1) begin
								gp_r[bank][gp_wr_sel][7:0] <= gp_wr_data[7:0];
							end
						end
						crf_mode_high: begin
							if (gp_wr_sel <= IX_D1) begin
								gp_r[bank][gp_wr_sel][15:8] <= gp_wr_data[7:0];
							end
						end
						crf_mode_pair: begin
							if (gp_wr_sel <= IX_D1) begin
								gp_r[bank][gp_wr_sel] <= {8'h00, gp_wr_data[15:0]};
								gp_r[bank][gp_wr_sel + IX_D2] <= {8'h00, gp_wr_data[31:16]};
							end
						end
						default: begin
							gp_r[bank][gp_wr_sel] <= {8'h00, gp_wr_data[15:0]};
						end
					endcase
				end
			end
		end
	end

	// Registered read of the active bank
	always_ff @(posedge mclk) begin
		if (srst) begin
			gp_rd_data_r <= 32'h00000000;
		end else if (ce) begin
			if (gp_rd_sel >= IX_A0) begin
				gp_rd_data_r <= {8'h00, gp_r[bank][gp_rd_sel]};
			end else begin
				case (crf_mode_t'(gp_rd_mode))
					crf_mode_low: gp_rd_data_r <= {24'h000000, gp_r[bank][gp_rd_sel][7:0]};
					crf_mode_high: gp_rd_data_r <= {24'h000000, gp_r[bank][gp_rd_sel][15:8]};
					crf_mode_pair: begin
						gp_rd_data_r <= {gp_r[bank][gp_rd_sel | IX_D2][15:0],
							gp_r[bank][gp_rd_sel & IX_D1][15:0]};
					end
					default: gp_rd_data_r <= {16'h0000, gp_r[bank][gp_rd_sel][15:0]};
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ip_r <= REG_RST;
			vtb_r <= REG_RST;
		end else if (ce) begin
			if (sw_we && (sw_addr_r == OFS_IP)) begin
				ip_r <= (ip_r & ~wr_mask) | (sw_data_r[23:0] & wr_mask);
			end
			if (sw_we && (sw_addr_r == OFS_VTB)) begin
				vtb_r <= (vtb_r & ~wr_mask) | (sw_data_r[23:0] & wr_mask);
			end
			if (ip_load) begin
				ip_r <= ip_next;
			end
			if (vtb_load) begin
				vtb_r <= vtb_data;
			end
		end
	end

	// stack pointers, core loads the selected one
	always_ff @(posedge mclk) begin
		if (srst) begin
			usp_r <= REG_RST;
			isp_r <= REG_RST;
		end else if (ce) begin
			if (sw_we && (sw_addr_r == OFS_USP)) begin
				usp_r <= (usp_r & ~wr_mask) | (sw_data_r[23:0] & wr_mask);
			end
			if (sw_we && (sw_addr_r == OFS_ISP)) begin
				isp_r <= (isp_r & ~wr_mask) | (sw_data_r[23:0] & wr_mask);
			end
			if (sp_load && usel) begin
				usp_r <= sp_data;
			end
			if (sp_load && !usel) begin
				isp_r <= sp_data;
			end
		end
	end

	// status word; later lines take precedence
	always_ff @(posedge mclk) begin
		if (srst) begin
			psw_r <= PSW_RST;
		end else if (ce) begin
			if (sw_we && (sw_addr_r == OFS_PSW)) begin
				psw_r <= ((psw_r & ~wr_mask[15:0]) | (sw_data_r[15:0] & wr_mask[15:0]))
					& PSW_USED;
			end
			if (psw_load) begin
				psw_r <= psw_data & PSW_USED;
			end
			if (alu_upd) begin
				if (alu_upd_mask[0]) psw_r[PSW_C] <= alu_carry;
				if (alu_upd_mask[1]) psw_r[PSW_Z] <= z_nxt;
				if (alu_upd_mask[2]) psw_r[PSW_S] <= s_nxt;
				if (alu_upd_mask[3]) psw_r[PSW_O] <= alu_ovf;
			end
			if (int_ack) begin
				psw_r[PSW_I] <= 1'b0;
				psw_r[PSW_U] <= 1'b0;
				psw_r[PSW_IPL_HI:PSW_IPL_LO] <= int_new_lvl;
			end
			if (trap_exec) begin
				psw_r[PSW_I] <= 1'b0;
				if (trap_num <= TRAP_SWITCH_MAX) begin
					psw_r[PSW_U] <= 1'b0;
				end
			end
		end
	end

	// region decode of the address space
	// vectors at top, RAM from 0x000400
	crf_addr_decode u_dec (
		.addr(mem_addr),
		.hit_sfr(region_r_sfr),
		.hit_ram(region_r_ram),
		.hit_rom(region_r_rom),
		.hit_spvec(region_r_spv),
		.hit_fixvec(region_r_fxv),
		.hit_none(region_r_none)
	);

	// Registered region flags
	always_ff @(posedge mclk) begin
		if (srst) begin
			region_r <= 6'h00;
		end else if (ce) begin
			region_r <= {region_r_ram, region_r_rom, region_r_spv, region_r_fxv,
				region_r_none, region_r_sfr};
		end
	end

	// Software window decode
	always_comb begin
		sw_rd = 32'h00000000;
		sw_rd_hit = 1'b1;
		if (s_axi_araddr[1:0] != 2'h0) begin
			sw_rd_hit = 1'b0;
		end else if (s_axi_araddr < OFS_IP) begin
			sw_rd = {8'h00, gp_r[s_axi_araddr[5]][s_axi_araddr[4:2]]};
		end else begin
			case (s_axi_araddr)
				OFS_IP: sw_rd = {8'h00, ip_r};
				OFS_VTB: sw_rd = {8'h00, vtb_r};
				OFS_USP: sw_rd = {8'h00, usp_r};
				OFS_ISP: sw_rd = {8'h00, isp_r};
				OFS_PSW: sw_rd = {16'h0000, psw_r};
				default: sw_rd_hit = 1'b0;
			endcase
		end
	end
	assign sw_wr_hit = (sw_addr_r[1:0] == 2'h0) && (sw_addr_r <= OFS_PSW);

	// Write address and data capture, either order
	always_ff @(posedge mclk) begin
		if (srst) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			sw_addr_r <= 8'h00;
			sw_data_r <= 32'h00000000;
			sw_strb_r <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				sw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				sw_data_r <= s_axi_wdata;
				sw_strb_r <= s_axi_wstrb;
			end
			if (sw_we) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
			end
		end
	end

	// Write response
	always_ff @(posedge mclk) begin
		if (srst) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (ce) begin
			if (sw_we) begin
				bvalid_r <= 1'b1;
				bresp_r <= sw_wr_hit ? RESP_OKAY : RESP_DECERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Read channel
	always_ff @(posedge mclk) begin
		if (srst) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_r <= 1'b1;
				rdata_r <= sw_rd;
				rresp_r <= sw_rd_hit ? RESP_OKAY : RESP_DECERR;
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// Handshake outputs
	assign s_axi_awready = ce && !aw_got_r && !bvalid_r;
	assign s_axi_wready = ce && !w_got_r && !bvalid_r;
	assign s_axi_arready = ce && !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
endmodule
`default_nettype wire

// >>> verilog/crf_pkg.sv
package crf_pkg;
	// Register widths
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int PSW_W = 16;
	localparam int BANKS = 2;
	localparam int BANK_REGS = 8;
	localparam int IDX_W = 3;
	// Register index within a bank
	localparam logic [2:0] IX_D0 = 3'h0;
	localparam logic [2:0] IX_D1 = 3'h1;
	localparam logic [2:0] IX_D2 = 3'h2;
	localparam logic [2:0] IX_D3 = 3'h3;
	localparam logic [2:0] IX_A0 = 3'h4;
	// Status word field positions
	localparam int PSW_C = 0;
	localparam int PSW_D = 1;
	localparam int PSW_Z = 2;
	localparam int PSW_S = 3;
	localparam int PSW_B = 4;
	localparam int PSW_O = 5;
	localparam int PSW_I = 6;
	localparam int PSW_U = 7;
	localparam int PSW_IPL_LO = 12;
	localparam int PSW_IPL_HI = 14;
	localparam logic [15:0] PSW_USED = 16'h70ff;
	localparam logic [15:0] PSW_RST = 16'h0000;
	localparam logic [23:0] REG_RST = 24'h000000;
	// Access modes of the general register port
	typedef enum logic [1:0] {
		crf_mode_word, crf_mode_low, crf_mode_high, crf_mode_pair
	} crf_mode_t;
	// Operand width of an arithmetic result
	typedef enum logic [1:0] {
		crf_w8, crf_w16, crf_w32
	} crf_width_t;
	// Highest trap number that switches to the interrupt stack
	localparam logic [5:0] TRAP_SWITCH_MAX = 6'h1f;
	// Software register window byte addresses
	localparam logic [7:0] OFS_BANK0 = 8'h00;
	localparam logic [7:0] OFS_BANK1 = 8'h20;
	localparam logic [7:0] OFS_IP = 8'h40;
	localparam logic [7:0] OFS_VTB = 8'h44;
	localparam logic [7:0] OFS_USP = 8'h48;
	localparam logic [7:0] OFS_ISP = 8'h4c;
	localparam logic [7:0] OFS_PSW = 8'h50;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// Memory map
	localparam logic [23:0] MAP_SFR_TOP = 24'h0003ff;
	localparam logic [23:0] MAP_RAM_BASE = 24'h000400;
	localparam logic [23:0] MAP_SPVEC_BASE = 24'hfffe00;
	localparam logic [23:0] MAP_FIXVEC_BASE = 24'hffffdc;
endpackage

// >>> verilog/crf_addr_decode.sv
`timescale 1ns/1ps
`default_nettype none
module crf_addr_decode
	import crf_pkg::*;
#(
	parameter logic [23:0] RAM_TOP = 24'h002bff,
	parameter logic [23:0] ROM_BASE = 24'hff0000
) (
	input wire logic [23:0] addr, // Address being decoded
	output logic hit_sfr, // Peripheral register area
	output logic hit_ram, // On-chip RAM
	output logic hit_rom, // Internal memory below the top
	output logic hit_spvec, // Special page vectors
	output logic hit_fixvec, // Fixed interrupt vectors
	output logic hit_none // Reserved, not accessible
);
	// Coarse split of the 16-Mbyte space
	always_comb begin
		hit_sfr = (addr <= MAP_SFR_TOP);
		hit_ram = (addr >= MAP_RAM_BASE) && (addr <= RAM_TOP);
		hit_fixvec = (addr >= MAP_FIXVEC_BASE);
		hit_spvec = (addr >= MAP_SPVEC_BASE) && !hit_fixvec;
		hit_rom = (addr >= ROM_BASE) && !hit_fixvec && !hit_spvec;
		hit_none = !(hit_sfr || hit_ram || hit_fixvec || hit_spvec || hit_rom);
	end
endmodule
`default_nettype wire

// >>> dv/crf_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Temporal checks on status word, decoder and instruction pointer output
module crf_top_sva
	import crf_pkg::*;
(
	input wire logic mclk, // Clock
	input wire logic srst, // Reset
	input wire logic ce, // Enable
	input wire logic ip_load, // Load
	input wire logic [23:0] ip_next, // Value
	input wire logic [23:0] ip_out, // Pointer
	input wire logic alu_upd, // Result valid
	input wire logic [3:0] alu_upd_mask, // Flag mask
	input wire logic [1:0] alu_width, // Width
	input wire logic [31:0] alu_result, // Result
	input wire logic alu_carry, // Carry
	input wire logic alu_ovf, // Overflow
	input wire logic int_req, // Request
	input wire logic [2:0] int_req_lvl, // Level
	input wire logic int_take, // Accept
	input wire logic int_ack, // Acknowledge
	input wire logic [2:0] int_new_lvl, // New level
	input wire logic trap_exec, // Trap
	input wire logic [5:0] trap_num, // Trap number
	input wire logic [15:0] psw_out, // Status word
	input wire logic [23:0] mem_addr, // Address
	input wire logic [5:0] mem_region // Region
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);
	a_take_gate: assert property (
		int_take == (int_req && psw_out[PSW_I] && int_req_lvl > psw_out[14:12]))
		else $error("accept flag wrong");
	a_ack_clear: assert property (
		ce && int_ack |=> psw_out[7:6] == 2'h0 && psw_out[14:12] == $past(int_new_lvl))
		else $error("acknowledge did not clear flags");
	a_trap_clear: assert property (
		ce && trap_exec && trap_num <= TRAP_SWITCH_MAX |=> psw_out[7:6] == 2'h0)
		else $error("low trap kept stack select");
	a_alu_zs: assert property (
		ce && alu_upd && alu_upd_mask[2:1] == 2'h3 && alu_width == 2'h1 && !int_ack
		&& !trap_exec |=> psw_out[PSW_Z] == ($past(alu_result[15:0]) == 16'h0)
		&& psw_out[PSW_S] == $past(alu_result[15])) else $error("zero or sign wrong");
	a_alu_co: assert property (
		ce && alu_upd && alu_upd_mask[3] && alu_upd_mask[0] && !int_ack && !trap_exec
		|=> psw_out[PSW_C] == $past(alu_carry) && psw_out[PSW_O] == $past(alu_ovf))
		else $error("carry or overflow wrong");
	a_region_ends: assert property (
		ce |=> mem_region[0] == ($past(mem_addr) <= MAP_SFR_TOP)
		&& mem_region[2] == ($past(mem_addr) >= MAP_FIXVEC_BASE))
		else $error("peripheral or vector region wrong");
	a_region_ram: assert property (
		ce |=> mem_region[5] == ($past(mem_addr) >= MAP_RAM_BASE
		&& $past(mem_addr) <= 24'h002bff)) else $error("ram region wrong");
	a_ip_load: assert property (
		ce && ip_load |=> ip_out == $past(ip_next)) else $error("pointer load lost");
	a_freeze_hold: assert property (
		!ce |=> $stable(psw_out) && $stable(ip_out)) else $error("state moved while frozen");
	a_psw_resv: assert property (
		(psw_out & ~PSW_USED) == 16'h0) else $error("reserved status bits set");
endmodule
bind crf_top crf_top_sva u_crf_top_sva (.mclk, .srst, .ce, .ip_load, .ip_next, .ip_out,
	.alu_upd, .alu_upd_mask, .alu_width, .alu_result, .alu_carry, .alu_ovf, .int_req,
	.int_req_lvl, .int_take, .int_ack, .int_new_lvl, .trap_exec, .trap_num, .psw_out,
	.mem_addr, .mem_region);
`default_nettype wire

// >>> dv/crf_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module crf_top_tb_top
	import crf_pkg::*;
();
	// Inputs start idle with reset held
	logic mclk = 0, srst = 1, ce = 1, gp_wr_en = 0, ip_load = 0, vtb_load = 0, sp_load = 0;
	logic psw_load = 0, alu_upd = 0, alu_carry = 0, alu_ovf = 0, int_req = 0, int_ack = 0;
	logic trap_exec = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [1:0] gp_wr_mode = '0, gp_rd_mode = '0, alu_width = '0;
	logic [2:0] gp_wr_sel = '0, gp_rd_sel = '0, int_req_lvl = '0, int_new_lvl = '0;
	logic [3:0] alu_upd_mask = '0, s_axi_wstrb = '0;
	logic [5:0] trap_num = '0, mem_region;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [15:0] psw_data = '0, psw_out;
	logic [23:0] ip_next = '0, vtb_data = '0, sp_data = '0, mem_addr = '0, ip_out, vtb_out, sp_out;
	logic [31:0] gp_wr_data = '0, alu_result = '0, s_axi_wdata = '0, gp_rd_data, s_axi_rdata;
	logic int_take, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int err_count = 0;
	int n_tests = 0;
	crf_top u_crf_top (.mclk, .srst, .ce, .gp_wr_en, .gp_wr_sel, .gp_wr_mode, .gp_wr_data,
		.gp_rd_sel, .gp_rd_mode, .gp_rd_data, .ip_load, .ip_next, .ip_out, .vtb_load,
		.vtb_data, .vtb_out, .sp_load, .sp_data, .sp_out, .psw_load, .psw_data, .alu_upd,
		.alu_upd_mask, .alu_width, .alu_result, .alu_carry, .alu_ovf, .int_req, .int_req_lvl,
		.int_take, .int_ack, .int_new_lvl, .trap_exec, .trap_num, .psw_out, .mem_addr,
		.mem_region, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// Core clock
	initial begin
		forever #2 mclk = ~mclk;
	end
	// Counts and verdict
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Ends the run when a bounded wait ran out
	task automatic fin(input logic ok);
		if (ok !== 1'b1) begin
			err_count++;
			print_verdict();
		end
	endtask
	// Register write over the bus, response judged
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ra, rw, done = 1'b0;
		logic [1:0] r = '0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 40 && !done; i++) begin
			@(negedge mclk);
			ra = s_axi_awready & s_axi_awvalid;
			rw = s_axi_wready & s_axi_wvalid;
			done = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge mclk);
			if (ra) s_axi_awvalid <= 1'b0;
			if (rw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		fin(done);
		chk(32'(r), 32'(er));
	endtask
	// Register read over the bus, data and response judged
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ra, done = 1'b0;
		logic [1:0] r = '0;
		logic [31:0] d = '0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 40 && !done; i++) begin
			@(negedge mclk);
			ra = s_axi_arready & s_axi_arvalid;
			done = s_axi_rvalid;
			r = s_axi_rresp;
			d = s_axi_rdata;
			@(posedge mclk);
			if (ra) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		fin(done);
		chk(d, e);
		chk(32'(r), 32'(er));
	endtask
	// Core register port write and read
	task automatic gwr(input logic [2:0] s, input logic [1:0] m, input logic [31:0] d);
		@(posedge mclk);
		gp_wr_en <= 1'b1;
		gp_wr_sel <= s;
		gp_wr_mode <= m;
		gp_wr_data <= d;
		@(posedge mclk);
		gp_wr_en <= 1'b0;
	endtask
	task automatic grd(input logic [2:0] s, input logic [1:0] m, input logic [31:0] e);
		@(posedge mclk);
		gp_rd_sel <= s;
		gp_rd_mode <= m;
		@(posedge mclk);
		#1 chk(gp_rd_data, e);
	endtask
	task automatic pswld(input logic [15:0] d);
		@(posedge mclk);
		psw_load <= 1'b1;
		psw_data <= d;
		@(posedge mclk);
		psw_load <= 1'b0;
		#1;
	endtask
	// Every register of both banks keeps its own width
	task automatic t_banks();
		logic [31:0] v;
		for (int b = 0; b < 2; b++) begin
			pswld(16'(b << 4));
			for (int s = 0; s < 8; s++) gwr(3'(s), crf_mode_word, 32'hdeadbe00 | 32'(b * 8 + s));
		end
		for (int b = 0; b < 2; b++) begin
			pswld(16'(b << 4));
			for (int s = 0; s < 8; s++) begin
				v = 32'hdeadbe00 | 32'(b * 8 + s);
				v = (s < 4) ? v & 32'hffff : v & 32'hffffff;
				grd(3'(s), crf_mode_word, v);
				axi_rd(8'(b * 32 + s * 4), v, RESP_OKAY);
			end
		end
	endtask
	// Byte halves, pairs, and a byte write refused on data 2
	task automatic t_halves();
		pswld(16'h0000);
		gwr(IX_D0, crf_mode_word, 32'h1111);
		gwr(IX_D0, crf_mode_low, 32'haa);
		gwr(IX_D0, crf_mode_high, 32'h55);
		grd(IX_D0, crf_mode_word, 32'h55aa);
		grd(IX_D0, crf_mode_high, 32'h55);
		grd(IX_D0, crf_mode_low, 32'haa);
		gwr(IX_D1, crf_mode_pair, 32'h12345678);
		grd(IX_D3, crf_mode_word, 32'h1234);
		grd(IX_D1, crf_mode_pair, 32'h12345678);
		gwr(IX_D2, crf_mode_low, 32'hff);
		grd(IX_D0, crf_mode_pair, 32'hbe0255aa);
	endtask
	// Pointers, stack select and a frozen clock enable
	task automatic t_ptrs();
		@(posedge mclk);
		sp_load <= 1'b1;
		sp_data <= 24'h123456; // even address
		ip_load <= 1'b1;
		ip_next <= 24'habcdef;
		vtb_load <= 1'b1;
		vtb_data <= 24'h100000;
		@(posedge mclk);
		sp_load <= 1'b0;
		ip_load <= 1'b0;
		vtb_load <= 1'b0;
		#1 chk(32'(sp_out), 32'h123456);
		chk(32'(vtb_out), 32'h100000);
		pswld(16'h0080);
		chk(32'(sp_out), 32'h0);
		@(posedge mclk);
		sp_load <= 1'b1;
		sp_data <= 24'h654320; // even address
		@(posedge mclk);
		sp_load <= 1'b0;
		axi_rd(OFS_USP, 32'h654320, RESP_OKAY);
		axi_rd(OFS_ISP, 32'h123456, RESP_OKAY);
		axi_rd(OFS_IP, 32'habcdef, RESP_OKAY);
		axi_rd(OFS_VTB, 32'h100000, RESP_OKAY);
		@(posedge mclk);
		ce <= 1'b0;
		ip_load <= 1'b1;
		ip_next <= 24'h000002;
		@(posedge mclk);
		ce <= 1'b1;
		ip_load <= 1'b0;
		#1 chk(32'(ip_out), 32'habcdef);
	endtask
	// Flag update with width, mask and result
	task automatic alu(input logic [1:0] w, input logic [31:0] r, input logic c, input logic o,
		input logic [3:0] m, input logic [3:0] e);
		@(posedge mclk);
		alu_upd <= 1'b1;
		alu_upd_mask <= m;
		alu_width <= w;
		alu_result <= r;
		alu_carry <= c;
		alu_ovf <= o;
		@(posedge mclk);
		alu_upd <= 1'b0;
		#1 chk({28'h0, psw_out[5], psw_out[3:2], psw_out[0]}, {28'h0, e});
	endtask
	// Interrupt acceptance, acknowledge and trap numbers
	task automatic t_int();
		logic [5:0] tn [4] = '{6'h00, 6'h1f, 6'h20, 6'h3f};
		logic [2:0] lv [3] = '{3'h3, 3'h4, 3'h7};
		logic [15:0] pw [3] = '{16'h3040, 16'h3040, 16'h3000};
		for (int k = 0; k < 3; k++) begin
			pswld(pw[k]);
			@(posedge mclk);
			int_req <= 1'b1;
			int_req_lvl <= lv[k];
			#1 chk(32'(int_take), 32'(k == 1));
		end
		pswld(16'h30c0);
		@(posedge mclk);
		int_ack <= 1'b1;
		int_new_lvl <= 3'h5;
		@(posedge mclk);
		int_ack <= 1'b0;
		#1 chk(32'(psw_out), 32'h5000);
		for (int k = 0; k < 4; k++) begin
			pswld(16'h00c0);
			@(posedge mclk);
			trap_exec <= 1'b1;
			trap_num <= tn[k];
			@(posedge mclk);
			trap_exec <= 1'b0;
			#1 chk(32'(psw_out), (tn[k] > 6'h1f) ? 32'h80 : 32'h0);
		end
	endtask
	// Status word over the bus, refused and unmapped places
	task automatic t_axi();
		axi_wr(OFS_PSW, 32'hfffffffd, RESP_OKAY);
		#1 chk(32'(psw_out), 32'h70fd);
		axi_wr(OFS_BANK1, 32'h1234, RESP_OKAY);
		grd(IX_D0, crf_mode_word, 32'h1234);
		axi_wr(8'h21, 32'hffff, RESP_DECERR);
		grd(IX_D0, crf_mode_word, 32'h1234);
		axi_wr(8'h54, 32'h1, RESP_DECERR);
		axi_wr(8'h52, 32'h1, RESP_DECERR);
		axi_rd(8'h54, 32'h0, RESP_DECERR);
		axi_rd(OFS_PSW, 32'h70fd, RESP_OKAY);
	endtask
	// Region boundaries of the address space
	task automatic t_decode();
		logic [23:0] ad [12] = '{24'h000000, 24'h0003ff, 24'h000400, 24'h002bff, 24'h002c00,
			24'hfeffff, 24'hff0000, 24'hfffdff, 24'hfffe00, 24'hffffdb, 24'hffffdc, 24'hffffff};
		logic [5:0] er [12] = '{6'h01, 6'h01, 6'h20, 6'h20, 6'h02, 6'h02, 6'h10, 6'h10, 6'h08,
			6'h08, 6'h04, 6'h04};
		for (int k = 0; k < 12; k++) begin
			@(posedge mclk);
			mem_addr <= ad[k];
			@(posedge mclk);
			#1 chk(32'(mem_region), 32'(er[k]));
		end
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		#1 chk(32'(psw_out), 32'h0);
		t_banks();
		t_halves();
		t_ptrs();
		alu(crf_w8, 32'h100, 1'b1, 1'b0, 4'hf, 4'b0011);
		alu(crf_w16, 32'h8000, 1'b0, 1'b1, 4'hf, 4'b1100);
		alu(crf_w32, 32'h80000000, 1'b0, 1'b0, 4'hf, 4'b0100);
		alu(crf_w16, 32'h10000, 1'b1, 1'b1, 4'hf, 4'b1011);
		alu(crf_w32, 32'h0, 1'b0, 1'b0, 4'h0, 4'b1011);
		t_int();
		t_axi();
		t_decode();
		print_verdict();
	end
endmodule
`default_nettype wire
